// File: verilog/ccs_pkg.sv
package ccs_pkg;

  localparam int CLK_PERIOD_NS      = 10;
  localparam int RECHG_DEGLITCH_US  = 100;
  localparam int RECHG_DG_CYCLES    = (RECHG_DEGLITCH_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ALERT_WIDTH_NS     = 1000;
  localparam int ALERT_CYCLES       = ALERT_WIDTH_NS / CLK_PERIOD_NS;
  localparam int BLINK_HALF_MS      = 500;
  localparam int BLINK_CYCLES       = BLINK_HALF_MS * 1000000 / CLK_PERIOD_NS;
  localparam int TICK_MS            = 1000;
  localparam int TICK_CYCLES        = TICK_MS * 100000;

  localparam logic [4:0] ADDR_CTRL    = 5'h00;
  localparam logic [4:0] ADDR_STATUS  = 5'h04;
  localparam logic [4:0] ADDR_CURRENT = 5'h08;
  localparam logic [4:0] ADDR_TERM    = 5'h0C;
  localparam logic [4:0] ADDR_VREG    = 5'h10;

  localparam int CTRL_EN_BIT      = 0;
  localparam int CTRL_TERM_BIT    = 1;
  localparam int CTRL_IND_OFF_BIT = 2;
  localparam int CTRL_FLOOR_BIT   = 3;
  localparam int CTRL_HALF_BIT    = 4;
  localparam int CTRL_MASK_BIT    = 5;
  localparam int CTRL_RESTORE_BIT = 6;
  localparam int CTRL_RECHG_LSB   = 8;
  localparam int CTRL_TOPOFF_LSB  = 10;

  localparam logic [31:0] CTRL_RESET    = 32'h0000_0113;
  localparam logic [31:0] CURRENT_RESET = 32'h07D0_0078;
  localparam logic [31:0] TERM_RESET    = 32'h020C_00C8;
  localparam logic [31:0] VREG_RESET   = 32'h00B4_20D0;

  localparam logic [15:0] TRICKLE_MA       = 16'h0064;
  localparam logic [15:0] TRICKLE_EXIT_MV  = 16'h0898;
  localparam logic [15:0] RECHG_STEP_MV    = 16'h0064;

  typedef enum logic [2:0] {
    PH_IDLE    = 3'b000,
    PH_TRICKLE = 3'b001,
    PH_PRE     = 3'b010,
    PH_FAST    = 3'b011,
    PH_TAPER   = 3'b100,
    PH_TOPOFF  = 3'b110,
    PH_DONE    = 3'b111
  } ccs_phase_t;

  typedef struct packed {
    logic vbus_present;
    logic ce_n;
    logic vbat_below_recharge;
    logic vbat_below_trickle_exit;
    logic vbat_below_precharge_exit;
    logic vbat_at_reg;
    logic ibat_below_term;
    logic vsys_below_vbat;
    logic vbat_below_depletion;
    logic vin_loop;
    logic iin_loop;
    logic thermal_loop;
    logic ts_fault;
    logic timer_fault;
  } ccs_pins_t;

  localparam int              PINS_W     = 14;
  localparam logic [13:0]     PINS_RESET = 14'h1000;

  typedef struct packed {
    logic [15:0] current_ma;
    logic [15:0] trickle_exit_mv;
    logic [15:0] precharge_exit_mv;
    logic [15:0] recharge_mv;
    logic [15:0] term_ma;
    logic [7:0]  fast_tmr_h;
    logic [7:0]  pre_tmr_h;
    logic        battery_switch;
    logic        half_rate;
    logic        timer_suspend;
    logic        sys_floor_active;
  } ccs_out_t;

  function automatic logic [11:0] ccs_topoff_secs(input logic [1:0] code);
    case (code)
      2'b01:   ccs_topoff_secs = 12'h384;
      2'b10:   ccs_topoff_secs = 12'h708;
      2'b11:   ccs_topoff_secs = 12'hA8C;
      default: ccs_topoff_secs = 12'h000;
    endcase
  endfunction

endpackage

// File: verilog/ccs_charge_cycle_sequencer.sv
`timescale 1ns/100ps
module ccs_charge_cycle_sequencer import ccs_pkg::*; #(
  parameter int unsigned DG_CYCLES    = RECHG_DG_CYCLES,
  parameter int unsigned BLINK_HALF   = BLINK_CYCLES,
  parameter int unsigned TICK_PERIOD  = TICK_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output      logic [31:0] avs_readdata,
  output      logic        avs_waitrequest,
  input  wire ccs_pins_t   pins_in,
  output      ccs_phase_t  charge_phase_code,
  output      ccs_out_t    ctl,
  output      logic        alert_n,
  output      logic        stat_out,
  output      logic        stat_oe_n
);

  logic [PINS_W-1:0] s1, s2, s3, pin_v;
  ccs_pins_t         pin;
  logic [31:0]       ctrl, cur_reg, term_reg, vreg_reg;
  logic [31:0]       dg_cnt, blink_cnt, tick_cnt;
  logic [11:0]       topoff_secs;
  logic [1:0]        topoff_sel;
  logic [7:0]        alert_cnt;
  ccs_phase_t        phase, phase_q, next_phase;
  logic              en, en_q, en_rise, below_dg, restart_req, fault, loop_active;
  logic              charging, start_ok, term_ok, stop, wr_ok, restore;
  logic              supp, half_tgl, blink, topoff_expire, topoff_step;
  logic [23:0]       pre_prod;
  logic [31:0]       rd_mux;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    merge = r;
  endfunction

  function automatic ccs_phase_t pick(input ccs_pins_t p);
    if (p.vbat_below_trickle_exit) begin
      pick = PH_TRICKLE;
    end else if (p.vbat_below_precharge_exit) begin
      pick = PH_PRE;
    end else begin
      pick = PH_FAST;
    end
  endfunction

  // three-stage synchroniser; a change is accepted once stages two and three agree
  always_ff @(posedge clk) begin
    if (!rstn) begin
      s1    <= PINS_RESET;
      s2    <= PINS_RESET;
      s3    <= PINS_RESET;
      pin_v <= PINS_RESET;
    end else begin
      s1    <= pins_in;
      s2    <= s1;
      s3    <= s2;
      pin_v <= (s2 & s3) | (pin_v & (s2 ^ s3));
    end
  end
  assign pin = ccs_pins_t'(pin_v);

  // bus slave: one wait cycle, then waitrequest low for exactly one edge
  assign wr_ok   = avs_write && !avs_waitrequest;
  assign restore = wr_ok && avs_address == ADDR_CTRL && avs_byteenable[0] && avs_writedata[CTRL_RESTORE_BIT];

  always_ff @(posedge clk) begin
    if (!rstn) begin
      avs_waitrequest <= 1'b1;
    end else if ((avs_read || avs_write) && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  always_comb begin
    if (avs_address == ADDR_CTRL) begin
      rd_mux = ctrl;
    end else if (avs_address == ADDR_STATUS) begin
      rd_mux = {21'h000000, fault, ctl.sys_floor_active, ctl.timer_suspend, ctl.half_rate, supp,
                ctl.battery_switch, pin.iin_loop, pin.vin_loop, phase};
    end else if (avs_address == ADDR_CURRENT) begin
      rd_mux = cur_reg;
    end else if (avs_address == ADDR_TERM) begin
      rd_mux = term_reg;
    end else if (avs_address == ADDR_VREG) begin
      rd_mux = vreg_reg;
    end else begin
      rd_mux = 32'h0000_0000;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= rd_mux;
    end
  end

  // restore bit is self-clearing and returns every setting to its power-on value
  always_ff @(posedge clk) begin
    if (!rstn || restore) begin
      ctrl     <= CTRL_RESET;
      cur_reg  <= CURRENT_RESET;
      term_reg <= TERM_RESET;
      vreg_reg <= VREG_RESET;
    end else if (wr_ok) begin
      if (avs_address == ADDR_CTRL) begin
        ctrl <= merge(ctrl, avs_writedata, avs_byteenable) & ~(32'h1 << CTRL_RESTORE_BIT);
      end else if (avs_address == ADDR_CURRENT) begin
        cur_reg <= merge(cur_reg, avs_writedata, avs_byteenable);
      end else if (avs_address == ADDR_TERM) begin
        term_reg <= merge(term_reg, avs_writedata, avs_byteenable);
      end else if (avs_address == ADDR_VREG) begin
        vreg_reg <= merge(vreg_reg, avs_writedata, avs_byteenable);
      end
    end
  end

  assign en          = ctrl[CTRL_EN_BIT] && !pin.ce_n;
  assign en_rise     = en && !en_q;
  assign fault       = pin.ts_fault || pin.timer_fault;
  assign loop_active = pin.vin_loop || pin.iin_loop || pin.thermal_loop;
  assign charging    = phase == PH_TRICKLE || phase == PH_PRE || phase == PH_FAST || phase == PH_TAPER;
  assign below_dg    = dg_cnt == 32'(DG_CYCLES);
  assign stop        = !pin.vbus_present || !en || fault;
  assign start_ok    = pin.vbus_present && en && !fault && (below_dg || restart_req);
  // allow bit is read only while the cycle is still before termination
  assign term_ok     = pin.ibat_below_term && !pin.vbat_below_recharge && !loop_active
                       && ctrl[CTRL_TERM_BIT];

  always_ff @(posedge clk) begin
    if (!rstn) begin
      en_q <= 1'b0;
    end else begin
      en_q <= en;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn || !pin.vbat_below_recharge) begin
      dg_cnt <= 32'h0000_0000;
    end else if (!below_dg) begin
      dg_cnt <= dg_cnt + 32'h0000_0001;
    end
  end

  // an enable toggle restarts even a full battery
  always_ff @(posedge clk) begin
    if (!rstn) begin
      restart_req <= 1'b0;
    end else if (en_rise) begin
      restart_req <= 1'b1;
    end else if (charging) begin
      restart_req <= 1'b0;
    end
  end

  always_comb begin
    next_phase = phase;
    case (phase)
      PH_IDLE, PH_DONE: begin
        if (start_ok) begin
          next_phase = pick(pin);
        end
      end
      PH_TRICKLE, PH_PRE: begin
        next_phase = pick(pin);
      end
      PH_FAST: begin
        next_phase = pin.vbat_at_reg ? PH_TAPER : pick(pin);
      end
      PH_TAPER: begin
        if (term_ok) begin
          next_phase = (ctrl[CTRL_TOPOFF_LSB +: 2] != 2'b00) ? PH_TOPOFF : PH_DONE;
        end
      end
      PH_TOPOFF: begin
        if (topoff_expire) begin
          next_phase = PH_DONE;
        end
      end
      default: begin
        next_phase = PH_IDLE;
      end
    endcase
    if (stop && phase != PH_IDLE) begin
      next_phase = PH_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      phase   <= PH_IDLE;
      phase_q <= PH_IDLE;
    end else begin
      phase   <= next_phase;
      phase_q <= phase;
    end
  end
  assign charge_phase_code = phase;

  always_ff @(posedge clk) begin
    if (!rstn || restore) begin
      topoff_sel <= 2'b00;
    end else if (phase == PH_TAPER && next_phase != PH_TAPER && next_phase != PH_IDLE) begin
      topoff_sel <= ctrl[CTRL_TOPOFF_LSB +: 2];
    end
  end

  // top-off clock stalls with the safety timer and steps every other cycle at half rate
  assign topoff_step   = !ctl.timer_suspend && (!ctl.half_rate || half_tgl);
  assign topoff_expire = topoff_secs >= ccs_topoff_secs(topoff_sel);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      half_tgl <= 1'b0;
    end else begin
      half_tgl <= !half_tgl;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn || restore || en_rise || (phase != PH_TOPOFF && next_phase == PH_TOPOFF)) begin
      tick_cnt    <= 32'h0000_0000;
      topoff_secs <= 12'h000;
    end else if (phase == PH_TOPOFF && topoff_step) begin
      if (tick_cnt == 32'(TICK_PERIOD - 1)) begin
        tick_cnt    <= 32'h0000_0000;
        topoff_secs <= topoff_secs + 12'h001;
      end else begin
        tick_cnt <= tick_cnt + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      supp <= 1'b0;
    end else if (pin.vbat_below_depletion) begin
      supp <= 1'b0;
    end else if (pin.vsys_below_vbat) begin
      supp <= 1'b1;
    end
  end

  assign pre_prod = 24'(vreg_reg[15:0]) * 24'(vreg_reg[23:16]);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctl <= '0;
    end else begin
      case (phase)
        PH_TRICKLE: ctl.current_ma <= TRICKLE_MA;
        PH_PRE:     ctl.current_ma <= cur_reg[15:0];
        PH_FAST, PH_TAPER, PH_TOPOFF: ctl.current_ma <= cur_reg[31:16];
        default:    ctl.current_ma <= 16'h0000;
      endcase
      ctl.trickle_exit_mv   <= TRICKLE_EXIT_MV;
      ctl.precharge_exit_mv <= pre_prod[23:8];
      ctl.recharge_mv       <= vreg_reg[15:0]
                               - 16'(RECHG_STEP_MV * ({14'h0000, ctrl[CTRL_RECHG_LSB +: 2]} + 16'h0001));
      ctl.term_ma           <= term_reg[15:0];
      ctl.fast_tmr_h        <= term_reg[23:16];
      ctl.pre_tmr_h         <= term_reg[31:24];
      ctl.battery_switch    <= charging || phase == PH_TOPOFF || supp;
      ctl.timer_suspend     <= fault || supp;
      ctl.sys_floor_active  <= !ctrl[CTRL_FLOOR_BIT] || phase == PH_TRICKLE;
      // once in half rate, stay there until regulation ends even if the enable drops
      if (!loop_active) begin
        ctl.half_rate <= 1'b0;
      end else if ((charging || phase == PH_TOPOFF) && ctrl[CTRL_HALF_BIT]) begin
        ctl.half_rate <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      alert_n   <= 1'b1;
      alert_cnt <= 8'h00;
    end else if (phase != phase_q && !ctrl[CTRL_MASK_BIT]) begin
      alert_n   <= 1'b0;
      alert_cnt <= 8'(ALERT_CYCLES - 1);
    end else if (alert_cnt != 8'h00) begin
      alert_cnt <= alert_cnt - 8'h01;
    end else begin
      alert_n <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn || blink_cnt == 32'(BLINK_HALF - 1)) begin
      blink_cnt <= 32'h0000_0000;
    end else begin
      blink_cnt <= blink_cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      blink <= 1'b0;
    end else if (blink_cnt == 32'(BLINK_HALF - 1)) begin
      blink <= !blink;
    end
  end

  // open-drain indicator: driving low is the lit state
  always_ff @(posedge clk) begin
    if (!rstn) begin
      stat_out  <= 1'b0;
      stat_oe_n <= 1'b1;
    end else if (ctrl[CTRL_IND_OFF_BIT]) begin
      stat_oe_n <= 1'b1;
    end else if (fault && pin.vbus_present && en) begin
      stat_oe_n <= blink;
    end else begin
      stat_oe_n <= !(charging || phase == PH_TOPOFF);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_taper_end;
    phase == PH_TAPER ##1 (phase == PH_TOPOFF || phase == PH_DONE);
  endsequence

  a_phase_alert: assert property ($changed(phase) && !ctrl[CTRL_MASK_BIT] |=> !alert_n)
    else $error("phase change without alert");
  a_alert_width: assert property ($fell(alert_n) |-> (!alert_n)[*8])
    else $error("alert pulse too short");
  a_start_gate: assert property ($rose(charging) |-> $past(pin.vbus_present && en && !fault))
    else $error("cycle started while not allowed");
  a_term_gate: assert property (s_taper_end |-> $past(pin.ibat_below_term && !pin.vbat_below_recharge
                                && !loop_active && ctrl[CTRL_TERM_BIT]))
    else $error("termination without criteria");
  a_fast_taper: assert property (phase == PH_FAST && pin.vbat_at_reg && !stop |=> phase == PH_TAPER)
    else $error("fast phase did not advance");
  a_done_switch: assert property ((phase == PH_DONE && !supp)[*2] |-> !ctl.battery_switch)
    else $error("switch closed after completion");
  a_topoff_switch: assert property (phase == PH_TOPOFF ##1 phase == PH_TOPOFF |-> ctl.battery_switch)
    else $error("switch open during top-off");
  a_topoff_hold: assert property (phase == PH_TOPOFF && $past(phase) == PH_TOPOFF && !$past(restore)
                                  |-> $stable(topoff_sel))
    else $error("top-off setting changed after termination");
  a_half_cause: assert property ($rose(ctl.half_rate) |-> $past(loop_active && ctrl[CTRL_HALF_BIT]))
    else $error("half rate without regulation");

endmodule

// File: sim/ccs_host_model.sv
`timescale 1ns/100ps
module ccs_host_model (
  input  wire logic        clk,
  output      logic [4:0]  avs_address,
  output      logic        avs_read,
  output      logic        avs_write,
  output      logic [31:0] avs_writedata,
  output      logic [3:0]  avs_byteenable,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest
);
  initial begin
    avs_address    = 5'h00;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = 32'h0;
    avs_byteenable = 4'hF;
  end

  // held until waitrequest is sampled low; only the bench timeout ends a hang
  task automatic xfer(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= w;
    avs_read      <= !w;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    q = avs_readdata;
    avs_read      <= 1'b0;
    avs_write     <= 1'b0;
    // released data must not keep looking valid
    avs_writedata <= ~d;
  endtask
endmodule

// File: sim/testbench.sv
`timescale 1ns/100ps
module testbench;
  import ccs_pkg::*;
  logic        clk;
  logic        rstn;
  logic [4:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  ccs_pins_t   p;
  ccs_phase_t  charge_phase_code;
  ccs_out_t    ctl;
  logic        alert_n;
  logic        stat_out;
  logic        stat_oe_n;
  int          n_errors = 0;
  int          check_count = 0;
  int          cyc = 0;
  int          n;
  logic [31:0] seed = 32'h15;
  logic [31:0] rd;
  logic [31:0] cur;
  logic        s;
  logic [4:0]  ra [5];
  logic [31:0] rv [5];

  initial clk = 1'b0;
  always #5 clk = ~clk;

  ccs_charge_cycle_sequencer #(.DG_CYCLES(4), .BLINK_HALF(8), .TICK_PERIOD(4)) ccs_charge_cycle_sequencer_i (
    .clk(clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .pins_in(p), .charge_phase_code(charge_phase_code), .ctl(ctl),
    .alert_n(alert_n), .stat_out(stat_out), .stat_oe_n(stat_oe_n));

  ccs_host_model host_i (
    .clk(clk), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));

  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    v = v ^ (v << 5);
    return v;
  endfunction

  function automatic logic [15:0] exp_ma(input int k, input logic [31:0] c);
    if (k == 0) return TRICKLE_MA;
    return (k == 1) ? c[15:0] : c[31:16];
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    host_i.xfer(1'b1, a, d, rd);
  endtask

  task automatic rdr(input logic [4:0] a);
    host_i.xfer(1'b0, a, 32'h0, rd);
  endtask

  task automatic wait_ph(input ccs_phase_t ph, input int lim);
    int i;
    i = 0;
    while (charge_phase_code !== ph && i < lim) begin
      @(posedge clk);
      i++;
    end
  endtask

  task automatic alert_win;
    s = 1'b0;
    repeat (6) begin
      @(posedge clk);
      if (alert_n === 1'b0) s = 1'b1;
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      wrap_up;
    end
  end

  initial begin
    rstn = 1'b0;
    p    = PINS_RESET;
    cur  = CURRENT_RESET;
    ra   = '{ADDR_CTRL, ADDR_CURRENT, ADDR_TERM, ADDR_VREG, 5'h14};
    rv   = '{CTRL_RESET, CURRENT_RESET, TERM_RESET, VREG_RESET, 32'h0};
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    chk(charge_phase_code, PH_IDLE);
    chk(stat_oe_n, 1'b1);
    chk(ctl.term_ma, 16'h00C8);
    chk(ctl.fast_tmr_h, 8'h0C);
    chk(ctl.pre_tmr_h, 8'h02);
    chk(ctl.recharge_mv, VREG_RESET[15:0] - 16'h00C8);
    chk(ctl.trickle_exit_mv, 16'h0898);
    chk(ctl.precharge_exit_mv, 16'h1712);
    chk(ctl.sys_floor_active, 1'b1);
    chk(stat_out, 1'b0);
    for (int i = 0; i < 5; i++) begin
      rdr(ra[i]);
      chk(rd, rv[i]);
    end
    // start from each battery level, then drop the input
    p.vbat_below_recharge <= 1'b1;
    p.ce_n                <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      p.vbus_present              <= 1'b1;
      p.vbat_below_trickle_exit   <= (k == 0);
      p.vbat_below_precharge_exit <= (k < 2);
      wait_ph(ccs_phase_t'(k + 1), 100);
      chk(charge_phase_code, k + 1);
      // the current output follows the phase register by one edge
      @(posedge clk);
      chk(ctl.current_ma, exp_ma(k, cur));
      alert_win;
      chk(s, 1'b1);
      chk(stat_oe_n, 1'b0);
      p.vbus_present <= 1'b0;
      wait_ph(PH_IDLE, 50);
      chk(charge_phase_code, PH_IDLE);
    end
    p.ts_fault     <= 1'b1;
    p.vbus_present <= 1'b1;
    repeat (10) @(posedge clk);
    s = stat_oe_n;
    n = 0;
    repeat (40) begin
      @(posedge clk);
      if (stat_oe_n !== s) n++;
      s = stat_oe_n;
    end
    chk(n >= 2, 1'b1);
    chk(ctl.timer_suspend, 1'b1);
    chk(charge_phase_code, PH_IDLE);
    p.ts_fault <= 1'b0;
    wait_ph(PH_FAST, 100);
    chk(charge_phase_code, PH_FAST);
    for (int i = 0; i < 3; i++) begin
      seed = xs(seed);
      cur  = {5'h00, seed[26:16], 5'h00, seed[10:0]};
      wr(ADDR_CURRENT, cur);
      rdr(ADDR_CURRENT);
      chk(rd, cur);
      chk(ctl.current_ma, cur[31:16]);
    end
    wr(ADDR_STATUS, 32'hFFFF_FFFF);
    rdr(ADDR_STATUS);
    chk(rd[2:0], PH_FAST);
    wr(ADDR_CTRL, CTRL_RESET | 32'h30C);
    repeat (3) @(posedge clk);
    chk(stat_oe_n, 1'b1);
    chk(ctl.sys_floor_active, 1'b0);
    chk(ctl.recharge_mv, VREG_RESET[15:0] - 16'h0190);
    wr(ADDR_CTRL, CTRL_RESET);
    p.vbat_at_reg <= 1'b1;
    wait_ph(PH_TAPER, 50);
    chk(charge_phase_code, PH_TAPER);
    p.ibat_below_term     <= 1'b1;
    p.vbat_below_recharge <= 1'b0;
    p.vin_loop            <= 1'b1;
    repeat (30) @(posedge clk);
    chk(charge_phase_code, PH_TAPER);
    chk(ctl.half_rate, 1'b1);
    rdr(ADDR_STATUS);
    chk(rd[4:3], 2'b01);
    p.vin_loop <= 1'b0;
    wait_ph(PH_DONE, 50);
    chk(charge_phase_code, PH_DONE);
    alert_win;
    chk(s, 1'b1);
    chk(ctl.battery_switch, 1'b0);
    p.vsys_below_vbat <= 1'b1;
    repeat (8) @(posedge clk);
    chk(ctl.battery_switch, 1'b1);
    p.vbat_below_depletion <= 1'b1;
    repeat (8) @(posedge clk);
    chk(ctl.battery_switch, 1'b0);
    p.vsys_below_vbat      <= 1'b0;
    p.vbat_below_depletion <= 1'b0;
    p.vbat_at_reg          <= 1'b0;
    p.ibat_below_term      <= 1'b0;
    p.vbat_below_recharge  <= 1'b1;
    wait_ph(PH_FAST, 100);
    chk(charge_phase_code, PH_FAST);
    // termination held off, top-off enabled but must not start
    wr(ADDR_CTRL, (CTRL_RESET & ~32'h2) | 32'h400);
    p.vbat_at_reg         <= 1'b1;
    p.ibat_below_term     <= 1'b1;
    p.vbat_below_recharge <= 1'b0;
    repeat (40) @(posedge clk);
    chk(charge_phase_code, PH_TAPER);
    wr(ADDR_CTRL, CTRL_RESET);
    wait_ph(PH_DONE, 50);
    chk(charge_phase_code, PH_DONE);
    p.vbat_at_reg     <= 1'b0;
    p.ibat_below_term <= 1'b0;
    wr(ADDR_CTRL, CTRL_RESET & ~32'h1);
    wait_ph(PH_IDLE, 50);
    chk(charge_phase_code, PH_IDLE);
    wr(ADDR_CTRL, CTRL_RESET);
    wait_ph(PH_FAST, 50);
    chk(charge_phase_code, PH_FAST);
    wr(ADDR_CTRL, CTRL_RESET | 32'h20);
    repeat (120) @(posedge clk);
    p.vbat_at_reg <= 1'b1;
    wait_ph(PH_TAPER, 50);
    alert_win;
    chk(s, 1'b0);
    wr(ADDR_CTRL, CTRL_RESET | 32'h400);
    p.ibat_below_term <= 1'b1;
    wait_ph(PH_TOPOFF, 50);
    chk(charge_phase_code, PH_TOPOFF);
    alert_win;
    chk(s, 1'b1);
    chk(ctl.battery_switch, 1'b1);
    // a longer setting written now must not stretch the running top-off
    wr(ADDR_CTRL, CTRL_RESET | 32'hC00);
    repeat (3300) @(posedge clk);
    chk(charge_phase_code, PH_TOPOFF);
    wait_ph(PH_DONE, 700);
    chk(charge_phase_code, PH_DONE);
    alert_win;
    chk(s, 1'b1);
    wrap_up;
  end
endmodule
